// ### design/ttlc_cfg.svh
/*
  Constants for the trigger/timestamp link and coincidence block: register
  offsets, field positions, link framing codes and timing counts.
  Assumes a 100 MHz system clock and a 16-bit register port from the bus FPGA.
*/
// What this block does
// - hardware status bit 10 shows link lock
// - command lock only after link clock selected
// - link config bit 15 selects recovered clock
// - pulsed bit 2 clears lost-lock bit 14
// - trigger from NIM 0 or ECL strobe
// - trigger edge sends timestamped message upstream if none is still being sent
// - received trigger message pulses a NIM output
// - trigger latches timestamp and writes FIFO record
// - readout lockout freezes the timestamp latch
// - command frames are processed only in command lock
// - FIFO read at one dedicated address
// - gating bits 0/1 choose coincidence start
// - delay equals delay register times 20ns
// - then window of window register length
// - NIM 1 edge in window pulses output 3
// - window closes empty, back to idle
// - 48-bit latch read as three words
`ifndef TTLC_CFG_SVH
`define TTLC_CFG_SVH

`define TTLC_ADDR_HW_STATUS 16'h0020
`define TTLC_ADDR_PULSED 16'h040c
`define TTLC_ADDR_GATING 16'h0702
`define TTLC_ADDR_LATCH_A 16'h0708
`define TTLC_ADDR_LATCH_B 16'h070a
`define TTLC_ADDR_LATCH_C 16'h070c
`define TTLC_ADDR_COINC_DLY 16'h0710
`define TTLC_ADDR_COINC_WIN 16'h0712
`define TTLC_ADDR_LINK_CFG 16'h0848
`define TTLC_ADDR_FIFO 16'h1000

`define TTLC_HW_PHYS_LOCK_BIT 10
`define TTLC_HW_CMD_LOCK_BIT 13
`define TTLC_HW_LOST_LOCK_BIT 14
`define TTLC_HW_FIFO_EMPTY_BIT 0
`define TTLC_HW_FIFO_FULL_BIT 1
`define TTLC_PULSE_CLR_LOST_BIT 2
`define TTLC_LINK_CLK_SEL_BIT 15
`define TTLC_GATE_START_NIM_BIT 0
`define TTLC_GATE_START_LINK_BIT 1
`define TTLC_GATE_SRC_ECL_BIT 4

`define TTLC_GATING_RESET 16'h0000
`define TTLC_COINC_DLY_RESET 16'h0000
`define TTLC_COINC_WIN_RESET 16'h0000
`define TTLC_LINK_CFG_RESET 16'h0000

`define TTLC_SYNC_BYTE 8'hbc
`define TTLC_CMD_TRIGGER 8'h01
`define TTLC_CMD_AUX_TRIG 8'h02
`define TTLC_TX_BITS 7'd64

`define TTLC_CLK_NS 10
`define TTLC_TICK_NS 20
`define TTLC_TICK_CYC (`TTLC_TICK_NS / `TTLC_CLK_NS)
`define TTLC_OUT_PULSE_NS 50
`define TTLC_OUT_PULSE_CYC (`TTLC_OUT_PULSE_NS / `TTLC_CLK_NS)

`endif

// ### design/ttlc_pkg.sv
/*
  Types shared by the trigger/timestamp link and coincidence block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ttlc_pkg;
  typedef enum logic [2:0] {
    TTLC_CO_IDLE = 3'b001,
    TTLC_CO_DELAY = 3'b010,
    TTLC_CO_WINDOW = 3'b100
  } ttlc_coinc_t;

  typedef enum logic [2:0] {
    TTLC_RX_HUNT = 3'b001,
    TTLC_RX_CMD = 3'b010,
    TTLC_RX_SYNC = 3'b100
  } ttlc_rx_t;

  typedef logic [47:0] ttlc_ts_t;
endpackage : ttlc_pkg

// ### design/ttlc_fifo.sv
/*
  Small FIFO for timestamp records, with registered read data.
  Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module ttlc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt, push, pop;
  logic [WIDTH-1:0] od_r;

  // the output register counts as one of the DEPTH places
  assign in_ready = ((cnt_r + (AW+1)'(ov_r)) != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = ov_r;
  assign out_data = od_r;

  always_comb begin
    push = in_valid && in_ready;
    pop = (cnt_r != '0) && (!ov_r || out_ready);
    wr_nxt = push ? wr_r + AW'(1) : wr_r;
    rd_nxt = pop ? rd_r + AW'(1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
    end
  end

  // storage carries no reset so it can map onto block memory
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
    if (pop) begin
      od_r <= mem[rd_r];
    end
  end
endmodule : ttlc_fifo
`default_nettype wire

// ### design/ttlc_top.sv
/*
  Trigger/timestamp serial link endpoint with trigger latching, FIFO
  records and a delay/window coincidence machine.
  Assumes the bus FPGA presents a 16-bit register port on clk_sys, and that
  link clock, link data and front panel inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ttlc_cfg.svh"
module ttlc_top #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port from the bus FPGA
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // serial link pins
  input wire logic link_clk,
  input wire logic link_rx_data,
  input wire logic link_phys_lock,
  output logic link_tx_data,
  output logic clk_sel_link,
  // front panel
  input wire logic nim_in0,
  input wire logic nim_in1,
  input wire logic ecl_strobe_trigger_input,
  output logic nim_out_link_trig,
  output logic nim_out3_coinc
);
  import ttlc_pkg::*;

  localparam int NSYNC = 6;
  logic [NSYNC-1:0] meta_r, sync_r, prev_r;
  logic lclk_s, lrx_s, lock_s, nim0_s, nim1_s, ecl_s;
  logic lclk_rise, nim0_rise, nim1_rise, trig_rise;

  logic [15:0] gating_r, gating_nxt, dly_r, dly_nxt, win_r, win_nxt;
  logic [15:0] lcfg_r, lcfg_nxt, rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt, lost_r, lost_nxt;
  ttlc_ts_t ts_r, ts_nxt, latch_r, latch_nxt;
  logic lockout_r, lockout_nxt, latch_hold;
  logic tick_r, tick_nxt;

  ttlc_rx_t rx_r, rx_nxt;
  logic [7:0] rxsh_r, rxsh_nxt, rxbyte;
  logic [2:0] rxbit_r, rxbit_nxt;
  logic link_trig_evt, cmd_lock;

  logic [63:0] txsh_r, txsh_nxt;
  logic [6:0] txcnt_r, txcnt_nxt;
  logic tx_r, tx_nxt;

  ttlc_coinc_t co_r, co_nxt;
  logic [15:0] cocnt_r, cocnt_nxt;
  logic co_hit, co_start;
  logic [3:0] plink_r, plink_nxt, pco_r, pco_nxt;
  logic olink_r, olink_nxt, oco_r, oco_nxt;

  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [47:0] f_out_data;
  logic [1:0] fword_r, fword_nxt;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : hit

  // every pin passes two flops; edges are seen only past the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= {ecl_strobe_trigger_input, nim_in1, nim_in0, link_phys_lock,
                 link_rx_data, link_clk};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign {ecl_s, nim1_s, nim0_s, lock_s, lrx_s, lclk_s} = sync_r;
  assign lclk_rise = lclk_s & ~prev_r[0];
  assign nim0_rise = nim0_s & ~prev_r[3];
  assign nim1_rise = nim1_s & ~prev_r[4];
  // trigger source choice; an ECL edge is ignored while NIM 0 is selected
  assign trig_rise = gating_r[`TTLC_GATE_SRC_ECL_BIT] ? (ecl_s & ~prev_r[5])
                                                        : nim0_rise;
  assign rxbyte = {rxsh_r[6:0], lrx_s};
  assign cmd_lock = (rx_r != TTLC_RX_HUNT);
  // a trigger in the cycle that reads the high word must not tear the read
  assign latch_hold = lockout_r || (reg_rd && hit(reg_addr, `TTLC_ADDR_LATCH_A));
  assign f_in_valid = trig_rise;
  assign f_out_ready = reg_rd && hit(reg_addr, `TTLC_ADDR_FIFO) && f_out_valid
                       && (fword_r == 2'd2);

  ttlc_fifo #(
    .WIDTH(48),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(ts_r),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_comb begin
    gating_nxt = gating_r;
    dly_nxt = dly_r;
    win_nxt = win_r;
    lcfg_nxt = lcfg_r;
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    lockout_nxt = lockout_r;
    fword_nxt = fword_r;
    ts_nxt = ts_r + 48'd1;
    tick_nxt = ~tick_r;
    latch_nxt = latch_r;
    if (trig_rise && !latch_hold) begin
      latch_nxt = ts_r;
    end
    if (reg_wr) begin
      case (reg_addr)
        `TTLC_ADDR_GATING: gating_nxt = reg_wdata;
        `TTLC_ADDR_COINC_DLY: dly_nxt = reg_wdata;
        `TTLC_ADDR_COINC_WIN: win_nxt = reg_wdata;
        `TTLC_ADDR_LINK_CFG: lcfg_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `TTLC_ADDR_HW_STATUS: begin
          rdata_nxt = '0;
          rdata_nxt[`TTLC_HW_PHYS_LOCK_BIT] = lock_s;
          rdata_nxt[`TTLC_HW_CMD_LOCK_BIT] = cmd_lock;
          rdata_nxt[`TTLC_HW_LOST_LOCK_BIT] = lost_r;
          rdata_nxt[`TTLC_HW_FIFO_EMPTY_BIT] = ~f_out_valid;
          rdata_nxt[`TTLC_HW_FIFO_FULL_BIT] = ~f_in_ready;
        end
        `TTLC_ADDR_GATING: rdata_nxt = gating_r;
        `TTLC_ADDR_COINC_DLY: rdata_nxt = dly_r;
        `TTLC_ADDR_COINC_WIN: rdata_nxt = win_r;
        `TTLC_ADDR_LINK_CFG: rdata_nxt = lcfg_r;
        `TTLC_ADDR_LATCH_A: begin
          rdata_nxt = latch_r[47:32];
          lockout_nxt = 1'b1;
        end
        `TTLC_ADDR_LATCH_B: rdata_nxt = latch_r[31:16];
        `TTLC_ADDR_LATCH_C: begin
          rdata_nxt = latch_r[15:0];
          lockout_nxt = 1'b0;
        end
        `TTLC_ADDR_FIFO: begin
          // record comes out high word first; an empty FIFO reads zero
          case (fword_r)
            2'd0: rdata_nxt = f_out_data[47:32];
            2'd1: rdata_nxt = f_out_data[31:16];
            default: rdata_nxt = f_out_data[15:0];
          endcase
          if (!f_out_valid) begin
            rdata_nxt = '0;
          end else begin
            fword_nxt = (fword_r == 2'd2) ? 2'd0 : fword_r + 2'd1;
          end
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // receive machine: hunts for the sync byte, then alternates command and sync
  always_comb begin
    rx_nxt = rx_r;
    rxsh_nxt = rxsh_r;
    rxbit_nxt = rxbit_r;
    link_trig_evt = 1'b0;
    lost_nxt = lost_r;
    if (reg_wr && hit(reg_addr, `TTLC_ADDR_PULSED)
        && reg_wdata[`TTLC_PULSE_CLR_LOST_BIT]) begin
      lost_nxt = 1'b0;
    end
    if (lclk_rise) begin
      rxsh_nxt = rxbyte;
      rxbit_nxt = rxbit_r + 3'd1;
    end
    case (rx_r)
      TTLC_RX_HUNT: begin
        // without the recovered clock the stream can not hold lock
        if (lclk_rise && lock_s && lcfg_r[`TTLC_LINK_CLK_SEL_BIT]
            && rxbyte == `TTLC_SYNC_BYTE) begin
          rx_nxt = TTLC_RX_CMD;
          rxbit_nxt = 3'd0;
        end
      end
      TTLC_RX_CMD: begin
        if (lclk_rise && rxbit_r == 3'd7) begin
          rx_nxt = TTLC_RX_SYNC;
          link_trig_evt = (rxbyte == `TTLC_CMD_TRIGGER);
        end
      end
      TTLC_RX_SYNC: begin
        if (lclk_rise && rxbit_r == 3'd7) begin
          rx_nxt = (rxbyte == `TTLC_SYNC_BYTE) ? TTLC_RX_CMD : TTLC_RX_HUNT;
        end
      end
      default: rx_nxt = TTLC_RX_HUNT;
    endcase
    if (cmd_lock && (!lock_s || !lcfg_r[`TTLC_LINK_CLK_SEL_BIT])) begin
      rx_nxt = TTLC_RX_HUNT;
    end
    if (cmd_lock && rx_nxt == TTLC_RX_HUNT) begin
      lost_nxt = 1'b1;
    end
  end

  // transmit: sync, command, then the 48-bit timestamp, msb first
  always_comb begin
    txsh_nxt = txsh_r;
    txcnt_nxt = txcnt_r;
    tx_nxt = tx_r;
    if (trig_rise && txcnt_r == 7'd0) begin
      txsh_nxt = {`TTLC_SYNC_BYTE, `TTLC_CMD_AUX_TRIG, ts_r};
      txcnt_nxt = `TTLC_TX_BITS;
    end else if (lclk_rise && txcnt_r != 7'd0) begin
      tx_nxt = txsh_r[63];
      txsh_nxt = {txsh_r[62:0], 1'b0};
      txcnt_nxt = txcnt_r - 7'd1;
    end else if (lclk_rise) begin
      tx_nxt = 1'b0;
    end
  end

  // coincidence machine on a 20ns tick; starts are ignored while busy
  always_comb begin
    co_nxt = co_r;
    cocnt_nxt = cocnt_r;
    co_hit = 1'b0;
    co_start = (gating_r[`TTLC_GATE_START_NIM_BIT] && nim0_rise)
               || (gating_r[`TTLC_GATE_START_LINK_BIT] && link_trig_evt);
    case (co_r)
      TTLC_CO_IDLE: begin
        if (co_start) begin
          co_nxt = TTLC_CO_DELAY;
          // counting from one makes a delay of N last N ticks
          cocnt_nxt = 16'd1;
        end
      end
      TTLC_CO_DELAY: begin
        if (tick_r) begin
          if (cocnt_r >= dly_r) begin
            co_nxt = TTLC_CO_WINDOW;
            cocnt_nxt = 16'd1;
          end else begin
            cocnt_nxt = cocnt_r + 16'd1;
          end
        end
      end
      TTLC_CO_WINDOW: begin
        if (nim1_rise) begin
          co_hit = 1'b1;
          co_nxt = TTLC_CO_IDLE;
        end else if (tick_r) begin
          if (cocnt_r >= win_r) begin
            co_nxt = TTLC_CO_IDLE;
          end else begin
            cocnt_nxt = cocnt_r + 16'd1;
          end
        end
      end
      default: co_nxt = TTLC_CO_IDLE;
    endcase
    plink_nxt = link_trig_evt ? 4'(`TTLC_OUT_PULSE_CYC) :
                (plink_r != 4'd0 ? plink_r - 4'd1 : 4'd0);
    pco_nxt = co_hit ? 4'(`TTLC_OUT_PULSE_CYC) : (pco_r != 4'd0 ? pco_r - 4'd1 : 4'd0);
    olink_nxt = (plink_nxt != 4'd0);
    oco_nxt = (pco_nxt != 4'd0);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gating_r <= `TTLC_GATING_RESET;
      dly_r <= `TTLC_COINC_DLY_RESET;
      win_r <= `TTLC_COINC_WIN_RESET;
      lcfg_r <= `TTLC_LINK_CFG_RESET;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      lost_r <= 1'b0;
      ts_r <= '0;
      latch_r <= '0;
      lockout_r <= 1'b0;
      tick_r <= 1'b0;
      fword_r <= '0;
      rx_r <= TTLC_RX_HUNT;
      rxsh_r <= '0;
      rxbit_r <= '0;
      txsh_r <= '0;
      txcnt_r <= '0;
      tx_r <= 1'b0;
      co_r <= TTLC_CO_IDLE;
      cocnt_r <= '0;
      plink_r <= '0;
      pco_r <= '0;
      olink_r <= 1'b0;
      oco_r <= 1'b0;
    end else begin
      gating_r <= gating_nxt;
      dly_r <= dly_nxt;
      win_r <= win_nxt;
      lcfg_r <= lcfg_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      lost_r <= lost_nxt;
      ts_r <= ts_nxt;
      latch_r <= latch_nxt;
      lockout_r <= lockout_nxt;
      tick_r <= tick_nxt;
      fword_r <= fword_nxt;
      rx_r <= rx_nxt;
      rxsh_r <= rxsh_nxt;
      rxbit_r <= rxbit_nxt;
      txsh_r <= txsh_nxt;
      txcnt_r <= txcnt_nxt;
      tx_r <= tx_nxt;
      co_r <= co_nxt;
      cocnt_r <= cocnt_nxt;
      plink_r <= plink_nxt;
      pco_r <= pco_nxt;
      olink_r <= olink_nxt;
      oco_r <= oco_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign link_tx_data = tx_r;
  assign clk_sel_link = lcfg_r[`TTLC_LINK_CLK_SEL_BIT];
  assign nim_out_link_trig = olink_r;
  assign nim_out3_coinc = oco_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_start_idle;
    co_r == TTLC_CO_IDLE && co_start;
  endsequence
  sequence s_in_delay;
    co_r == TTLC_CO_DELAY;
  endsequence

  chk_lock_status: assert property (reg_rd && reg_addr == `TTLC_ADDR_HW_STATUS |=>
    reg_rvalid && reg_rdata[10] == $past(lock_s))
    else $error("status lock bit wrong");
  chk_lock_needs_clk: assert property (!lcfg_r[15] |=> rx_r == TTLC_RX_HUNT)
    else $error("command lock without link clock");
  chk_clk_select: assert property (reg_wr && reg_addr == `TTLC_ADDR_LINK_CFG |=>
    clk_sel_link == $past(reg_wdata[15]))
    else $error("clock select not following config");
  chk_lost_sets: assert property (cmd_lock && !lock_s |=> lost_r)
    else $error("lost lock flag not set");
  chk_lost_clears: assert property (reg_wr && reg_addr == `TTLC_ADDR_PULSED && reg_wdata[2]
    && !cmd_lock |=> !lost_r)
    else $error("lost lock flag not cleared");
  chk_tx_load: assert property (trig_rise && txcnt_r == 0 |=> txcnt_r == 64
    && txsh_r[47:0] == $past(ts_r))
    else $error("trigger message not loaded");
  chk_link_pulse: assert property (link_trig_evt |=> nim_out_link_trig [*5])
    else $error("link trigger pulse too short");
  chk_latch_take: assert property (trig_rise && !latch_hold |=> latch_r == $past(ts_r))
    else $error("timestamp not latched");
  chk_latch_hold: assert property (lockout_r && !(reg_rd && reg_addr == `TTLC_ADDR_LATCH_C)
    |=> $stable(latch_r))
    else $error("latch changed during readout");
  chk_co_start: assert property (s_start_idle |=> s_in_delay)
    else $error("coincidence did not start");
  chk_co_busy: assert property (s_in_delay ##0 co_start && cocnt_r < dly_r |=>
    co_r == TTLC_CO_DELAY && cocnt_r == $past(cocnt_r) + 16'($past(tick_r)))
    else $error("start accepted while busy");
  chk_co_delay: assert property (s_in_delay ##0 dly_r == 0 && tick_r
    |=> co_r == TTLC_CO_WINDOW)
    else $error("zero delay not honoured");
  chk_co_hit: assert property (co_r == TTLC_CO_WINDOW && nim1_rise
    |=> co_r == TTLC_CO_IDLE ##1 nim_out3_coinc)
    else $error("coincidence pulse missing");
  chk_co_close: assert property (co_r == TTLC_CO_WINDOW && !nim1_rise && tick_r
    && cocnt_r >= win_r |=> co_r == TTLC_CO_IDLE ##1 !nim_out3_coinc)
    else $error("window did not close");
endmodule : ttlc_top
`default_nettype wire

// ### tb/ttlc_link_model.sv
/*
  Upstream trigger master model: sends sync/command frames msb first on a
  link clock of its own and collects the 64-bit messages the block returns.
  Assumes the bench changes the sync and command bytes just after frame starts.
*/
`timescale 1ns/1ps
`default_nettype none
module ttlc_link_model (
  // link pins
  output logic link_clk,
  output logic link_rx_data,
  output logic link_phys_lock,
  input wire logic link_tx_data,
  // bench control
  input wire logic run,
  input wire logic phys_up,
  input wire logic [7:0] sync_byte,
  input wire logic [7:0] cmd_byte,
  // bench observation
  output int n_frames,
  output logic [63:0] tx_msg,
  output int n_tx
);
  logic [7:0] cmd_r;
  logic [63:0] sh;
  int cnt;
  assign link_phys_lock = phys_up;
  // the stream is continuous; the 3 ns offset keeps edges off clk_sys edges
  initial begin
    link_clk = 1'b0;
    link_rx_data = 1'b0;
    n_frames = 0;
    #3;
    forever begin
      wait (run);
      n_frames++;
      for (int i = 0; i < 16; i++) begin
        if (i == 8) begin
          cmd_r = cmd_byte;
        end
        link_rx_data = (i < 8) ? sync_byte[7 - (i % 8)] : cmd_r[7 - (i % 8)];
        #40 link_clk = 1'b1;
        #40 link_clk = 1'b0;
      end
    end
  end
  // the block moves its line after each detected rise, so take it at the next
  initial begin
    cnt = 0;
    n_tx = 0;
    tx_msg = '0;
  end
  always @(posedge link_clk) begin
    if (cnt > 0 || link_tx_data === 1'b1) begin
      sh = {sh[62:0], link_tx_data};
      cnt++;
    end
    if (cnt == 64) begin
      tx_msg = sh;
      n_tx++;
      cnt = 0;
    end
  end
endmodule : ttlc_link_model
`default_nettype wire

// ### tb/ttlc_top_tb.sv
/*
  Self-checking bench for ttlc_top: register port tasks, link partner,
  front panel pulses, FIFO fill and drain, coincidence sweep.
  Assumes ttlc_cfg.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ttlc_cfg.svh"
module ttlc_top_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata, w;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
  logic link_clk, link_rx_data, link_phys_lock, link_tx_data, clk_sel_link;
  logic nim_in0 = 1'b0, nim_in1 = 1'b0, ecl_trig = 1'b0, lt, co, lt_q = 1'b0, co_q = 1'b0;
  logic run = 1'b1, phys_up = 1'b0;
  logic [7:0] sync_byte = `TTLC_SYNC_BYTE, cmd_byte = 8'h00;
  logic [63:0] tx_msg;
  logic [47:0] t1, t2, v;
  int n_frames, n_tx, fails = 0, n_tests = 0, n_lt = 0, n_co = 0;
  always #5 clk_sys = ~clk_sys;
  ttlc_top #(.FIFO_DEPTH(16)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_clk(link_clk),
    .link_rx_data(link_rx_data), .link_phys_lock(link_phys_lock),
    .link_tx_data(link_tx_data), .clk_sel_link(clk_sel_link), .nim_in0(nim_in0),
    .nim_in1(nim_in1), .ecl_strobe_trigger_input(ecl_trig),
    .nim_out_link_trig(lt), .nim_out3_coinc(co));
  ttlc_link_model u_lm (.link_clk(link_clk), .link_rx_data(link_rx_data),
    .link_phys_lock(link_phys_lock), .link_tx_data(link_tx_data), .run(run),
    .phys_up(phys_up), .sync_byte(sync_byte), .cmd_byte(cmd_byte),
    .n_frames(n_frames), .tx_msg(tx_msg), .n_tx(n_tx));
  // output pulses are counted at the falling edge, where they have settled
  always @(negedge clk_sys) begin
    lt_q <= lt;
    co_q <= co;
    if (lt === 1'b1 && lt_q !== 1'b1) n_lt++;
    if (co === 1'b1 && co_q !== 1'b1) n_co++;
  end
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    chk("reg_rvalid", 1'b1, reg_rvalid);
    d = reg_rdata;
  endtask : rd
  task automatic rd48(input logic [15:0] a, input logic [15:0] s, output logic [47:0] r);
    logic [15:0] x, y, z;
    rd(a, x);
    rd(a + s, y);
    rd(a + s + s, z);
    r = {x, y, z};
  endtask : rd48
  task automatic pin(input int p, input logic b);
    @(posedge clk_sys) #1;
    case (p)
      0: nim_in0 = b;
      1: nim_in1 = b;
      default: ecl_trig = b;
    endcase
  endtask : pin
  task automatic pulse(input int p, input int cyc);
    pin(p, 1'b1);
    repeat (cyc) @(posedge clk_sys);
    pin(p, 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask : pulse
  task automatic frames(input int n);
    int f;
    f = n_frames + n;
    for (int i = 0; i < 200 * n && n_frames < f; i++) @(posedge clk_sys);
    #1;
  endtask : frames
  task automatic wait_tx(input int k);
    for (int i = 0; i < 1200 && n_tx == k; i++) @(posedge clk_sys);
    #1;
  endtask : wait_tx
  task automatic s_regs;
    rd(`TTLC_ADDR_LINK_CFG, w);
    chk("link_config", `TTLC_LINK_CFG_RESET, w);
    rd(`TTLC_ADDR_COINC_DLY, w);
    chk("delay rst", `TTLC_COINC_DLY_RESET, w);
    wr(`TTLC_ADDR_COINC_DLY, 16'h000a);
    wr(`TTLC_ADDR_COINC_WIN, 16'h000a);
    rd(`TTLC_ADDR_COINC_DLY, w);
    chk("delay", 16'h000a, w);
    rd(`TTLC_ADDR_COINC_WIN, w);
    chk("window", 16'h000a, w);
    wr(16'h0002, 16'hffff);
    rd(16'h0002, w);
    chk("unmapped", 16'h0000, w);
    wr(`TTLC_ADDR_HW_STATUS, 16'hffff);
    rd(`TTLC_ADDR_HW_STATUS, w);
    chk("phys lock low", 1'b0, w[`TTLC_HW_PHYS_LOCK_BIT]);
  endtask : s_regs
  task automatic s_lock;
    int k;
    phys_up = 1'b1;
    frames(3);
    rd(`TTLC_ADDR_HW_STATUS, w);
    chk("phys lock", 1'b1, w[`TTLC_HW_PHYS_LOCK_BIT]);
    chk("early cmd lock", 1'b0, w[`TTLC_HW_CMD_LOCK_BIT]);
    for (int r = 0; r < 2; r++) begin
      wr(`TTLC_ADDR_LINK_CFG, 16'h8000);
      frames(3);
      chk("clk_sel_link", 1'b1, clk_sel_link);
      wr(`TTLC_ADDR_PULSED, 16'h0004);
      frames(2);
      rd(`TTLC_ADDR_HW_STATUS, w);
      chk("cmd lock", 1'b1, w[`TTLC_HW_CMD_LOCK_BIT]);
      chk("lost lock clear", 1'b0, w[`TTLC_HW_LOST_LOCK_BIT]);
      sync_byte = 8'h00;
      frames(2);
      sync_byte = `TTLC_SYNC_BYTE;
      frames(3);
      rd(`TTLC_ADDR_HW_STATUS, w);
      chk("lost lock set", 1'b1, w[`TTLC_HW_LOST_LOCK_BIT]);
    end
    wr(`TTLC_ADDR_PULSED, 16'h0004);
    k = n_lt;
    frames(1);
    cmd_byte = `TTLC_CMD_TRIGGER;
    frames(3);
    cmd_byte = 8'h00;
    frames(1);
    chk("link trig pulses", 3, n_lt - k);
  endtask : s_lock
  task automatic s_trig;
    int k;
    k = n_tx;
    pulse(0, 12);
    wait_tx(k);
    t1 = tx_msg[47:0];
    chk("tx head", {`TTLC_SYNC_BYTE, `TTLC_CMD_AUX_TRIG}, tx_msg[63:48]);
    rd48(`TTLC_ADDR_LATCH_A, 16'h0002, v);
    chk("latch", t1, v);
    rd(`TTLC_ADDR_LATCH_A, w);
    k = n_tx;
    pulse(0, 12);
    wait_tx(k);
    t2 = tx_msg[47:0];
    rd48(`TTLC_ADDR_LATCH_B, 16'h0002, v);
    chk("locked latch", t1, {w, v[47:32], v[31:16]});
    rd48(`TTLC_ADDR_FIFO, 16'h0000, v);
    chk("fifo rec 1", t1, v);
    rd48(`TTLC_ADDR_FIFO, 16'h0000, v);
    chk("fifo rec 2", t2, v);
    rd(`TTLC_ADDR_FIFO, w);
    chk("fifo empty read", 16'h0000, w);
  endtask : s_trig
  task automatic s_ecl_fill;
    int k;
    wr(`TTLC_ADDR_GATING, 16'h0010);
    k = n_tx;
    pulse(0, 12);
    repeat (700) @(posedge clk_sys);
    chk("nim0 ignored", k, n_tx);
    pulse(2, 12);
    wait_tx(k);
    chk("ecl trigger", k + 1, n_tx);
    wr(`TTLC_ADDR_GATING, 16'h0000);
    for (int i = 0; i < 17; i++) pulse(0, 12);
    rd(`TTLC_ADDR_HW_STATUS, w);
    chk("fifo full", 1'b1, w[`TTLC_HW_FIFO_FULL_BIT]);
    for (int i = 0; i < 16; i++) rd48(`TTLC_ADDR_FIFO, 16'h0000, v);
    rd(`TTLC_ADDR_HW_STATUS, w);
    chk("fifo drained", 1'b1, w[`TTLC_HW_FIFO_EMPTY_BIT]);
  endtask : s_ecl_fill
  // delay and window are both 20 cycles, so the window spans cycles 20 to 40
  task automatic coinc(input logic [15:0] g, input int gap, input int e);
    int k;
    wr(`TTLC_ADDR_GATING, g);
    k = n_co;
    pin(0, 1'b1);
    repeat (gap - 1) @(posedge clk_sys);
    pin(1, 1'b1);
    repeat (11) @(posedge clk_sys);
    pin(0, 1'b0);
    pin(1, 1'b0);
    repeat (60) @(posedge clk_sys);
    chk("coinc pulses", e, n_co - k);
  endtask : coinc
  task automatic s_link_coinc;
    int k, c;
    wr(`TTLC_ADDR_GATING, 16'h0003);
    k = n_co;
    c = n_lt;
    frames(1);
    cmd_byte = `TTLC_CMD_TRIGGER;
    frames(1);
    cmd_byte = 8'h00;
    for (int i = 0; i < 400 && n_lt == c; i++) @(posedge clk_sys);
    // a NIM 0 start lands in the delay and must not restart the sequence
    pulse(0, 12);
    repeat (8) @(posedge clk_sys);
    pulse(1, 12);
    repeat (40) @(posedge clk_sys);
    chk("link start coinc", 1, n_co - k);
  endtask : s_link_coinc
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    s_regs();
    s_lock();
    s_trig();
    s_ecl_fill();
    coinc(16'h0001, 30, 1);
    coinc(16'h0001, 10, 0);
    coinc(16'h0001, 60, 0);
    coinc(16'h0000, 30, 0);
    coinc(16'h0003, 30, 1);
    s_link_coinc();
    test_done();
  end
  // the sequence needs about 75 us
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule : ttlc_top_tb
`default_nettype wire
